/* rtl/coef_engine.sv */
`timescale 1ns/10ps
module coef_engine #(
   parameter int STAT_CYC = dac_pkg::STAT_ACC_CYC,
   parameter int RD_CYC   = dac_pkg::COEF_RD_CYC,
   parameter int WR_CYC   = dac_pkg::COEF_WR_CYC
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Requests
   input  wire logic       rd_req,
   input  wire logic       wr_req,
   input  wire logic       stat_rd,
   input  wire logic [6:0] addr,
   input  wire logic [7:0] wdata,
   // Status
   output logic [7:0]      rd_byte,
   output logic            rd_done,
   output logic            wr_busy
);
   import dac_pkg::*;
   localparam int CW = $clog2(WR_CYC + RD_CYC + STAT_CYC + 1);
   if (STAT_CYC < 1 || RD_CYC < 1 || WR_CYC < 1) $error("coef_engine: counts must be at least one");

   logic [7:0]  mem [128];
   coef_state_t ce_state;
   logic [CW-1:0] cnt_reg;
   logic [6:0]  addr_reg;
   logic [7:0]  wdata_reg;

   //------------------------------------------------------------
   // Sequencer
   //------------------------------------------------------------
   // Requests while busy are dropped; the host is expected to wait
   always_ff @(posedge mclk) begin
      if (rst) begin
         ce_state <= CE_IDLE;
         cnt_reg  <= '0;
         rd_done  <= 1'b0;
         wr_busy  <= 1'b0;
         rd_byte  <= '0;
         addr_reg <= '0;
         wdata_reg <= '0;
      end else begin
         unique case (ce_state)
            CE_IDLE: begin
               if (rd_req) begin
                  rd_done  <= 1'b0;
                  addr_reg <= addr;
                  cnt_reg  <= CW'(RD_CYC - 1);
                  ce_state <= CE_RD;
               end else if (wr_req) begin
                  wr_busy   <= 1'b1;
                  addr_reg  <= addr;
                  wdata_reg <= wdata;
                  cnt_reg   <= CW'(WR_CYC - 1);
                  ce_state  <= CE_WR;
               end else if (stat_rd) begin
                  cnt_reg  <= CW'(STAT_CYC - 1);
                  ce_state <= CE_STAT;
               end
            end
            default: begin
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - 1'b1;
               end else begin
                  if (ce_state == CE_RD) begin
                     rd_byte <= mem[addr_reg];
                     rd_done <= 1'b1;
                  end
                  if (ce_state == CE_WR) begin
                     wr_busy <= 1'b0;
                  end
                  ce_state <= CE_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst && ce_state == CE_WR && cnt_reg == '0) begin
         mem[addr_reg] <= wdata_reg;
      end
   end

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   chk_done_clear: assert property (@(posedge mclk) disable iff (rst)
      ce_state == CE_IDLE && rd_req |=> !rd_done [*8])
      else $error("read-complete flag not cleared by new read");
   chk_busy_hold: assert property (@(posedge mclk) disable iff (rst)
      ce_state == CE_IDLE && !rd_req && wr_req |=> wr_busy [*8])
      else $error("write busy flag dropped early");
endmodule : coef_engine

/* rtl/dac_ctrl.sv */
`timescale 1ns/10ps
module dac_ctrl #(
   parameter int          NUM_CH      = dac_pkg::NUM_CH_DOC,
   parameter bit          DAC_ZERO_WS = 1'b0,
   parameter logic [7:0]  COEF_WR_KEY = 8'hA5,
   parameter int          STAT_CYC    = dac_pkg::STAT_ACC_CYC,
   parameter int          RD_CYC      = dac_pkg::COEF_RD_CYC,
   parameter int          WR_CYC      = dac_pkg::COEF_WR_CYC
) (
   // Clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rst,
   // Carrier bus
   input  wire dac_pkg::host_req_t       bus_req,
   output dac_pkg::host_resp_t           bus_resp,
   output logic                          intreq0_n,
   // Triggers
   input  wire logic                     ext_trig_n,
   input  wire logic                     timer_tick,
   // Coefficient write enable code
   input  wire logic [7:0]               coef_key,
   // Waveform memory read port, data valid one cycle after address
   output logic [dac_pkg::WAVE_AW-1:0]   wave_addr,
   input  wire logic [NUM_CH*16-1:0]     wave_data,
   // Converters
   output logic [NUM_CH*16-1:0]          dac_out,
   output logic                          dac_load
);
   import dac_pkg::*;
   localparam int DW = $clog2(CONV_DELAY_CYC + 1);
   if (NUM_CH < 1 || NUM_CH > NUM_CH_DOC) $error("dac_ctrl: NUM_CH must be 1 to 8");

   //------------------------------------------------------------
   // Decoding
   //------------------------------------------------------------
   function automatic logic word_hit(input logic [5:0] a, input logic [7:0] off);
      word_hit = (a == off[6:1]);
   endfunction : word_hit

   function automatic logic dac_hit(input logic [5:0] a);
      dac_hit = (a[5:3] == OFF_DAC0[6:4]) && (int'(a[2:0]) < NUM_CH);
   endfunction : dac_hit

   function automatic logic [1:0] ws_of(input logic [5:0] a);
      ws_of = (DAC_ZERO_WS && dac_hit(a)) ? WAIT_NONE : WAIT_ONE;
   endfunction : ws_of

   //------------------------------------------------------------
   // Bus slave
   //------------------------------------------------------------
   bus_state_t  bus_state;
   host_req_t   req_reg;
   logic [1:0]  ws_cnt;
   logic        do_acc;
   logic        io_wr;
   logic        io_rd;
   logic        int_ack;
   logic        both_lanes;
   logic [15:0] rd_mux;

   // Request latched once; the carrier holds select until it sees ack
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus_state <= BS_IDLE;
         req_reg   <= '0;
         ws_cnt    <= '0;
      end else begin
         unique case (bus_state)
            BS_IDLE: begin
               if (!bus_req.sel_n || !bus_req.intsel_n) begin
                  req_reg   <= bus_req;
                  ws_cnt    <= ws_of(bus_req.addr);
                  bus_state <= BS_WAIT;
               end
            end
            BS_WAIT: begin
               if (ws_cnt == '0) begin
                  bus_state <= BS_HOLD;
               end else begin
                  ws_cnt <= ws_cnt - 1'b1;
               end
            end
            BS_HOLD: begin
               if (bus_req.sel_n && bus_req.intsel_n) begin
                  bus_state <= BS_IDLE;
               end
            end
            default: bus_state <= BS_IDLE;
         endcase
      end
   end

   assign do_acc     = (bus_state == BS_WAIT) && (ws_cnt == '0);
   assign io_wr      = do_acc && !req_reg.sel_n && !req_reg.wr_n;
   assign io_rd      = do_acc && !req_reg.sel_n && req_reg.wr_n;
   assign int_ack    = do_acc && req_reg.sel_n && !req_reg.intsel_n;
   assign both_lanes = (req_reg.be_n == 2'b00);

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   logic [15:0] ctrl_reg;
   logic [7:0]  vec_reg;
   logic [15:0] dac_reg [NUM_CH];
   logic [NUM_CH*16-1:0] dac_flat;
   logic [7:0]  coef_byte;
   logic        coef_done;
   logic        coef_busy;
   logic        coef_rd_req;
   logic        coef_wr_req;
   logic        stat_rd;

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_reg <= RESET_VAL;
      end else if (io_wr && word_hit(req_reg.addr, OFF_CTRL)) begin
         if (!req_reg.be_n[1]) ctrl_reg[15:8] <= req_reg.wdata[15:8];
         if (!req_reg.be_n[0]) ctrl_reg[7:0]  <= req_reg.wdata[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         vec_reg <= '0;
      end else if (io_wr && word_hit(req_reg.addr, OFF_VECTOR) && !req_reg.be_n[0]) begin
         vec_reg <= req_reg.wdata[7:0];
      end
   end

   // Byte-lane writes; one wait state unless the zero-wait variant is built
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      localparam logic [2:0] CH = 3'(i);
      always_ff @(posedge mclk) begin
         if (rst) begin
            dac_reg[i] <= RESET_VAL;
         end else if (io_wr && dac_hit(req_reg.addr) && req_reg.addr[2:0] == CH) begin
            if (!req_reg.be_n[1]) dac_reg[i][15:8] <= req_reg.wdata[15:8];
            if (!req_reg.be_n[0]) dac_reg[i][7:0]  <= req_reg.wdata[7:0];
         end
      end
      assign dac_flat[i*16 +: 16] = dac_reg[i];
   end

   // Coefficient access is 16-bit only; narrower writes are ignored
   assign coef_rd_req = io_wr && word_hit(req_reg.addr, OFF_COEF_ACC) && both_lanes
                        && req_reg.wdata[COEF_RD_BIT];
   assign coef_wr_req = io_wr && word_hit(req_reg.addr, OFF_COEF_ACC) && both_lanes
                        && !req_reg.wdata[COEF_RD_BIT] && (coef_key == COEF_WR_KEY);
   assign stat_rd     = io_rd && word_hit(req_reg.addr, OFF_COEF_STAT) && both_lanes;

   coef_engine #(
      .STAT_CYC (STAT_CYC),
      .RD_CYC   (RD_CYC),
      .WR_CYC   (WR_CYC)
   ) u_coef (
      .mclk     (mclk),
      .rst      (rst),
      .rd_req   (coef_rd_req),
      .wr_req   (coef_wr_req),
      .stat_rd  (stat_rd),
      .addr     (req_reg.wdata[COEF_ADDR_LSB +: 7]),
      .wdata    (req_reg.wdata[7:0]),
      .rd_byte  (coef_byte),
      .rd_done  (coef_done),
      .wr_busy  (coef_busy)
   );

   always_comb begin
      rd_mux = '0;
      if (int_ack || word_hit(req_reg.addr, OFF_VECTOR)) begin
         rd_mux = {8'h00, vec_reg};
      end else if (word_hit(req_reg.addr, OFF_COEF_STAT) && both_lanes) begin
         rd_mux = {coef_byte, 8'h00};
         rd_mux[STAT_BUSY_BIT] = coef_busy;
         rd_mux[STAT_DONE_BIT] = coef_done;
      end else if (word_hit(req_reg.addr, OFF_CTRL)) begin
         rd_mux = ctrl_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         bus_resp <= '{ack_n: 1'b1, data_oe_n: 1'b1, rdata: '0};
      end else if (do_acc) begin
         bus_resp.ack_n     <= 1'b0;
         bus_resp.data_oe_n <= !(io_rd || int_ack);
         bus_resp.rdata     <= (io_rd || int_ack) ? rd_mux : '0;
      end else begin
         bus_resp.ack_n     <= 1'b1;
         bus_resp.data_oe_n <= 1'b1;
      end
   end

   //------------------------------------------------------------
   // Conversion sequencer
   //------------------------------------------------------------
   conv_state_t cv_state;
   logic [DW-1:0] delay_cnt;
   logic [1:0]  trig_field;
   logic [2:0]  mode;
   logic        ext_prev;
   logic        ext_edge;
   logic        ext_only;
   logic        sw_start;
   logic        go_evt;
   logic        step_evt;
   logic        is_sgl;
   logic        is_cyc;
   logic        conv_fire;
   logic        irq_set;

   assign trig_field = ctrl_reg[CTRL_TRIG_LSB +: 2];
   assign mode       = ctrl_reg[CTRL_MODE_LSB +: 3];
   assign ext_edge   = ext_prev && !ext_trig_n;
   assign ext_only   = (trig_field == TRIG_EXT_ONLY);
   assign sw_start   = io_wr && word_hit(req_reg.addr, OFF_START) && !req_reg.be_n[0]
                       && req_reg.wdata[START_BIT];
   assign go_evt     = (sw_start && !ext_only) || ext_edge;
   assign step_evt   = (timer_tick && !ext_only) || ext_edge;
   assign is_sgl     = (mode == MODE_SGL_DAC) || (mode == MODE_SGL_WAVE) || (mode == MODE_SGL_WAVE_IRQ);
   assign is_cyc     = (mode == MODE_CYC_ONCE) || (mode == MODE_CYC_ONCE_IRQ);
   assign conv_fire  = (cv_state == CV_DELAY) && (delay_cnt == '0);

   always_ff @(posedge mclk) begin
      if (rst) begin
         ext_prev <= 1'b1;
      end else begin
         ext_prev <= ext_trig_n;
      end
   end

   // Triggers during the settling delay are dropped, not queued
   always_ff @(posedge mclk) begin
      if (rst) begin
         cv_state  <= CV_IDLE;
         delay_cnt <= '0;
         wave_addr <= '0;
      end else begin
         unique case (cv_state)
            CV_IDLE: begin
               if (go_evt && (is_sgl || is_cyc)) begin
                  delay_cnt <= DW'(CONV_DELAY_CYC - 1);
                  wave_addr <= '0;
                  cv_state  <= CV_DELAY;
               end
            end
            CV_DELAY: begin
               if (delay_cnt != '0) begin
                  delay_cnt <= delay_cnt - 1'b1;
               end else if (is_cyc && wave_addr != WAVE_LAST) begin
                  wave_addr <= wave_addr + 1'b1;
                  cv_state  <= CV_ARMED;
               end else begin
                  cv_state  <= CV_IDLE;
               end
            end
            CV_ARMED: begin
               if (!is_cyc) begin
                  cv_state <= CV_IDLE;
               end else if (step_evt) begin
                  delay_cnt <= DW'(CONV_DELAY_CYC - 1);
                  cv_state  <= CV_DELAY;
               end
            end
            default: cv_state <= CV_IDLE;
         endcase
      end
   end

   // One wide register load keeps every converter in step
   always_ff @(posedge mclk) begin
      if (rst) begin
         dac_out  <= '0;
         dac_load <= 1'b0;
      end else begin
         dac_load <= conv_fire;
         if (conv_fire) begin
            dac_out <= (mode == MODE_SGL_DAC) ? dac_flat : wave_data;
         end
      end
   end

   //------------------------------------------------------------
   // Interrupt request
   //------------------------------------------------------------
   assign irq_set = conv_fire && ((mode == MODE_SGL_WAVE_IRQ)
                    || (mode == MODE_CYC_ONCE_IRQ && wave_addr == WAVE_LAST));

   // Set wins over acknowledge so a finishing cycle is never lost
   always_ff @(posedge mclk) begin
      if (rst) begin
         intreq0_n <= 1'b1;
      end else if (irq_set) begin
         intreq0_n <= 1'b0;
      end else if (int_ack) begin
         intreq0_n <= 1'b1;
      end
   end

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   logic [DW-1:0] dly_seen;
   always_ff @(posedge mclk) begin
      if (rst || cv_state != CV_DELAY) begin
         dly_seen <= '0;
      end else begin
         dly_seen <= dly_seen + 1'b1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   chk_ack_wait: assert property (bus_state == BS_IDLE && !bus_req.sel_n |-> ##[2:3] !bus_resp.ack_n)
      else $error("bus ack outside wait-state window");
   chk_sw_block: assert property (cv_state == CV_IDLE && sw_start && ext_only && !ext_edge
      |=> cv_state == CV_IDLE)
      else $error("software start honoured in external-only mode");
   chk_conv_delay: assert property (conv_fire |-> dly_seen == DW'(CONV_DELAY_CYC - 1))
      else $error("conversion delay length wrong");
   chk_dac_same: assert property (conv_fire && mode == MODE_SGL_DAC |=> dac_load && dac_out == $past(dac_flat))
      else $error("channel registers not loaded together");
   chk_dac_clear: assert property (@(posedge mclk) disable iff (1'b0) $past(rst) |-> dac_flat == '0)
      else $error("channel registers not cleared by reset");
   chk_vec_release: assert property (int_ack && !irq_set |=> intreq0_n && bus_resp.rdata[7:0] == vec_reg)
      else $error("acknowledge cycle did not release request");
   chk_irq_last: assert property (conv_fire && mode == MODE_CYC_ONCE_IRQ && wave_addr == WAVE_LAST
      |=> !intreq0_n ##1 cv_state == CV_IDLE || !intreq0_n)
      else $error("no interrupt after final word");
   chk_cycle_stop: assert property (conv_fire && is_cyc && wave_addr == WAVE_LAST |=> cv_state == CV_IDLE)
      else $error("cycle-once did not stop after last word");
   chk_wave_step: assert property (conv_fire && is_cyc && wave_addr != WAVE_LAST
      |=> wave_addr == $past(wave_addr) + 1'b1 && cv_state == CV_ARMED)
      else $error("waveform address did not advance");
   chk_stat_word: assert property (stat_rd |=> bus_resp.rdata[15:8] == $past(coef_byte)
      && bus_resp.rdata[STAT_DONE_BIT] == $past(coef_done) && !bus_resp.data_oe_n)
      else $error("status word layout wrong");

   cov_single_dac: cover property (conv_fire && mode == MODE_SGL_DAC);
   cov_cycle_end: cover property (conv_fire && is_cyc && wave_addr == WAVE_LAST);
   cov_int_ack: cover property (!intreq0_n ##1 int_ack);
endmodule : dac_ctrl

/* rtl/dac_pkg.sv */
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
package dac_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_COEF_ACC  = 8'h0A;
   localparam logic [7:0] OFF_COEF_STAT = 8'h0C;
   localparam logic [7:0] OFF_START     = 8'h0F;
   localparam logic [7:0] OFF_DAC0      = 8'h10;
   localparam logic [7:0] OFF_VECTOR    = 8'h21;
   // Fields
   localparam int         CTRL_TRIG_LSB = 5;
   localparam int         CTRL_MODE_LSB = 8;
   localparam logic [1:0] TRIG_EXT_ONLY = 2'h1;
   localparam int         STAT_DONE_BIT = 0;
   localparam int         STAT_BUSY_BIT = 1;
   localparam int         COEF_RD_BIT   = 15;
   localparam int         COEF_ADDR_LSB = 8;
   localparam int         START_BIT     = 0;
   localparam logic [15:0] RESET_VAL    = 16'h0000;
   // Conversion modes
   localparam logic [2:0] MODE_SGL_DAC      = 3'h1;
   localparam logic [2:0] MODE_SGL_WAVE     = 3'h3;
   localparam logic [2:0] MODE_SGL_WAVE_IRQ = 3'h4;
   localparam logic [2:0] MODE_CYC_ONCE     = 3'h6;
   localparam logic [2:0] MODE_CYC_ONCE_IRQ = 3'h7;
   // Sizes
   localparam int NUM_CH_DOC  = 8;
   localparam int DATA_W      = 16;
   localparam int WAVE_AW     = 11;
   localparam logic [10:0] WAVE_LAST = 11'h7FF;
   localparam logic [1:0]  WAIT_ONE  = 2'h1;
   localparam logic [1:0]  WAIT_NONE = 2'h0;
   // Timing
   localparam int CLK_NS          = 5;
   localparam int T_CONV_DELAY_NS = 6625;
   localparam int T_STAT_ACC_US   = 1000;
   localparam int T_COEF_RD_US    = 2500;
   localparam int T_COEF_WR_US    = 5000;
   localparam int CONV_DELAY_CYC  = (T_CONV_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int STAT_ACC_CYC    = T_STAT_ACC_US * 1000 / CLK_NS;
   localparam int COEF_RD_CYC     = T_COEF_RD_US * 1000 / CLK_NS;
   localparam int COEF_WR_CYC     = T_COEF_WR_US * 1000 / CLK_NS;
   // Carriers
   typedef struct packed {
      logic        sel_n;
      logic        intsel_n;
      logic        wr_n;
      logic [5:0]  addr;
      logic [1:0]  be_n;
      logic [15:0] wdata;
   } host_req_t;
   typedef struct packed {
      logic        ack_n;
      logic        data_oe_n;
      logic [15:0] rdata;
   } host_resp_t;
   typedef enum logic [1:0] {BS_IDLE = 2'b00, BS_WAIT = 2'b01, BS_HOLD = 2'b10} bus_state_t;
   typedef enum logic [1:0] {CV_IDLE = 2'b00, CV_DELAY = 2'b01, CV_ARMED = 2'b10} conv_state_t;
   typedef enum logic [1:0] {CE_IDLE = 2'b00, CE_RD = 2'b01, CE_WR = 2'b10, CE_STAT = 2'b11} coef_state_t;
endpackage : dac_pkg

/* testbench/dac_update_and_cal_readout_tb.sv */
`timescale 1ns/10ps
module dac_update_and_cal_readout_tb;
   import dac_pkg::*;
   typedef struct {logic [5:0] a; logic [1:0] be; logic [15:0] d, e;} row_t;
   logic         mclk, rst, ext_trig_n, intreq0_n, dac_load, tick;
   host_req_t    req;
   host_resp_t   resp;
   logic [7:0]   coef_key;
   logic [10:0]  wave_addr;
   logic [127:0] wave_data, dac_out, exp_out;
   logic [15:0]  q;
   int           fail_count = 0, cmp_count = 0, n;
   row_t rows[4] = '{'{6'h10, 2'b10, 16'h005A, 16'h005A}, '{6'h10, 2'b00, 16'h12C3, 16'h00C3},
                     '{6'h00, 2'b00, 16'h0120, 16'h0120}, '{6'h3E, 2'b00, 16'hFFFF, 16'h0000}};
   dac_ctrl #(.STAT_CYC(20), .RD_CYC(50), .WR_CYC(100)) u_dac_ctrl (.mclk(mclk), .rst(rst), .bus_req(req),
      .bus_resp(resp), .intreq0_n(intreq0_n), .ext_trig_n(ext_trig_n), .timer_tick(tick), .coef_key(coef_key),
      .wave_addr(wave_addr), .wave_data(wave_data), .dac_out(dac_out), .dac_load(dac_load));
   wave_mem_model u_wave_mem_model (.mclk(mclk), .wave_addr(wave_addr), .wave_data(wave_data));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic cmp(input string what, input logic [127:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   // Select held until ack is seen, then released on the next rising edge
   task automatic bus(input logic ia, wr, input logic [5:0] a, input logic [1:0] be, input logic [15:0] d);
      int i;
      @(posedge mclk);
      req <= '{sel_n: ia, intsel_n: !ia, wr_n: !wr, addr: a, be_n: be, wdata: d};
      for (i = 0; i < 20 && resp.ack_n !== 1'b0; i++) @(negedge mclk);
      if (i == 20) begin
         fail_count++;
         tally_and_finish;
      end
      q = resp.rdata;
      cmp("data_oe_n", wr, resp.data_oe_n);
      @(posedge mclk);
      req.sel_n <= 1'b1;
      req.intsel_n <= 1'b1;
   endtask : bus
   task automatic wait_load(input int lim);
      for (n = 0; n < lim && dac_load !== 1'b1; n++) @(negedge mclk);
   endtask : wait_load
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      ext_trig_n = 1'b1;
      tick = 1'b0;
      coef_key = 8'h00;
      req = '{sel_n: 1'b1, intsel_n: 1'b1, wr_n: 1'b1, addr: 6'h00, be_n: 2'b11, wdata: 16'h0000};
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      bus(0, 0, 6'h06, 2'b00, 16'h0000);
      cmp("status", 0, q);
      cmp("dac_out", 0, dac_out);
      foreach (rows[r]) begin
         bus(0, 1, rows[r].a, rows[r].be, rows[r].d);
         bus(0, 0, rows[r].a, rows[r].be, 16'h0000);
         cmp("readback", rows[r].e, q);
      end
      bus(0, 1, 6'h00, 2'b00, 16'h0100);
      for (int c = 0; c < 8; c++) begin
         bus(0, 1, 6'h08 + c, 2'b00, 16'h1000 + c);
         exp_out[c*16+:16] = 16'h1000 + c;
      end
      for (int k = 0; k < 2; k++) begin
         if (k == 1) begin
            bus(0, 1, 6'h0B, 2'b01, 16'hBE00);
            bus(0, 1, 6'h0B, 2'b10, 16'h00EF);
            exp_out[3*16+:16] = 16'hBEEF;
         end
         bus(0, 1, 6'h07, 2'b10, 16'h0001);
         wait_load(1400);
         cmp("load", 1, n < 1400);
         cmp("dac_out", exp_out, dac_out);
      end
      bus(0, 1, 6'h00, 2'b00, 16'h0120);
      bus(0, 1, 6'h07, 2'b10, 16'h0001);
      wait_load(1500);
      cmp("sw start blocked", 0, n < 1500);
      @(posedge mclk) ext_trig_n <= 1'b0;
      @(posedge mclk) ext_trig_n <= 1'b1;
      wait_load(1500);
      cmp("ext load", 1, n < 1500);
      bus(0, 1, 6'h10, 2'b10, 16'h0077);
      bus(0, 1, 6'h00, 2'b00, 16'h0400);
      bus(0, 1, 6'h07, 2'b10, 16'h0001);
      wait_load(1400);
      for (int c = 0; c < 8; c++) exp_out[c*16+:16] = 16'(c) << 11;
      cmp("wave dac_out", exp_out, dac_out);
      @(negedge mclk);
      cmp("irq", 0, intreq0_n);
      bus(1, 0, 6'h00, 2'b11, 16'h0000);
      cmp("vector", 16'h0077, q);
      repeat (2) @(negedge mclk);
      cmp("irq", 1, intreq0_n);
      // Cycle-once: first word at address 0, next one only after a timer tick
      bus(0, 1, 6'h00, 2'b00, 16'h0600);
      bus(0, 1, 6'h07, 2'b10, 16'h0001);
      for (int s = 0; s < 2; s++) begin
         if (s == 1) begin
            @(posedge mclk) tick <= 1'b1;
            @(posedge mclk) tick <= 1'b0;
         end
         wait_load(1400);
         for (int c = 0; c < 8; c++) exp_out[c*16+:16] = (16'(c) << 11) | 16'(s);
         cmp("cycle dac_out", exp_out, dac_out);
      end
      // Wrong key first: the write must be dropped, busy stays low
      bus(0, 1, 6'h05, 2'b00, 16'h0533);
      bus(0, 0, 6'h06, 2'b00, 16'h0000);
      cmp("busy", 0, q[1]);
      repeat (30) @(posedge mclk);
      coef_key <= 8'hA5;
      bus(0, 1, 6'h05, 2'b00, 16'h0533);
      bus(0, 0, 6'h06, 2'b00, 16'h0000);
      cmp("busy", 1, q[1]);
      repeat (120) @(posedge mclk);
      bus(0, 0, 6'h06, 2'b00, 16'h0000);
      cmp("busy", 0, q[1]);
      repeat (30) @(posedge mclk);
      bus(0, 1, 6'h05, 2'b00, 16'h8500);
      bus(0, 0, 6'h06, 2'b00, 16'h0000);
      cmp("done", 0, q[0]);
      repeat (80) @(posedge mclk);
      bus(0, 0, 6'h06, 2'b00, 16'h0000);
      cmp("coef", 16'h3301, q);
      // A second read must drop the flag that the first one raised
      repeat (30) @(posedge mclk);
      bus(0, 1, 6'h05, 2'b00, 16'h8500);
      bus(0, 0, 6'h06, 2'b00, 16'h0000);
      cmp("done cleared", 16'h3300, q);
      // Reset in mid-run clears status, vector and converter words
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      bus(0, 0, 6'h06, 2'b00, 16'h0000);
      cmp("status after reset", 0, q);
      bus(0, 0, 6'h10, 2'b10, 16'h0000);
      cmp("vector after reset", 0, q);
      cmp("dac_out after reset", 0, dac_out);
      tally_and_finish;
   end
endmodule : dac_update_and_cal_readout_tb

/* testbench/wave_mem_model.sv */
`timescale 1ns/10ps
module wave_mem_model #(parameter int NUM_CH = 8) (
   // Memory port
   input  wire logic                mclk,
   input  wire logic [10:0]         wave_addr,
   output logic [NUM_CH*16-1:0]     wave_data
);
   // Word of ch i is {i, address}, so a wrong address or lane shows at once
   always_ff @(posedge mclk) begin
      for (int i = 0; i < NUM_CH; i++) wave_data[i*16+:16] <= {i[4:0], wave_addr};
   end
endmodule : wave_mem_model
